// [verilog/seq_pkg.sv]
// Constants, field layout and carrier types of the optical measurement sequencer
package seq_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;                          // System clock period
	localparam int SEQ_STEP_NS   = 1000;                        // Base sequencer step, 1 us
	localparam int STEP_CLKS     = SEQ_STEP_NS / CLK_PERIOD_NS; // Clocks per base step

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_TIMING  = 8'h04;
	localparam logic [7:0] OFS_LED     = 8'h30;
	localparam logic [7:0] OFS_ITG     = 8'h34;
	localparam logic [7:0] OFS_SDP     = 8'h38;
	localparam logic [7:0] OFS_SDM1    = 8'h3C;
	localparam logic [7:0] OFS_SDM2    = 8'h40;
	localparam logic [7:0] OFS_ADC     = 8'h44;
	localparam logic [7:0] OFS_SC      = 8'h70;
	localparam logic [7:0] OFS_SEQ_CNT = 8'h80;
	localparam logic [7:0] OFS_ADC_CNT = 8'h84;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT       = 0;
	localparam int CTRL_DEMOD_BIT    = 1;
	localparam int CTRL_SIGREF_BIT   = 2;
	localparam int CTRL_HPF_LSB      = 4;
	localparam int CTRL_PAT_A_LSB    = 8;
	localparam int CTRL_PAT_B_LSB    = 12;
	localparam int TIM_PERIOD_LSB    = 0;
	localparam int TIM_DIV_LSB       = 16;
	localparam int TIM_COUNT_LSB     = 24;
	localparam int WIN_STOP_LSB      = 0;
	localparam int WIN_START_LSB     = 16;
	localparam int ADC_BASE_LSB      = 0;
	localparam int ADC_INC_LSB       = 16;
	localparam int ADC_FRACT_LSB     = 24;
	localparam int ADC_INC_FRACT_LSB = 28;
	localparam int SC_SKIP_LSB       = 13;

	// Writable bit masks, reserved bits read as zero
	localparam logic [31:0] CTRL_MASK = 32'h0000_7737;
	localparam logic [31:0] SC_MASK   = 32'h001F_E000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_ITG  = 32'h0001_0000;

	// ----------------------------------------------------------------
	// Emitter patterns
	// ----------------------------------------------------------------
	localparam logic [2:0] PAT_OFF    = 3'h0;
	localparam logic [2:0] PAT_ALWAYS = 3'h2;
	localparam logic [2:0] PAT_EVEN   = 3'h3;
	localparam logic [2:0] PAT_ODD    = 3'h4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

	typedef struct packed {
		logic led_a;
		logic led_b;
		logic itg;
		logic adc_trig;
		logic demod_pos;
		logic demod_neg;
	} afe_ctl_t;

endpackage : seq_pkg

// [verilog/window_cmp.sv]
// Start/stop window comparator against the shared cycle counter
`timescale 1ns/1ps
`default_nettype none

module window_cmp #(
	parameter int W = 16
) (
	// Counter and bounds
	input  wire logic [W-1:0] i_count,
	input  wire logic [W-1:0] i_start,
	input  wire logic [W-1:0] i_stop,
	// Result
	output logic              o_active
);

	// Active from start up to, not including, stop
	assign o_active = (i_count >= i_start) && (i_count < i_stop); // R19

endmodule : window_cmp

`default_nettype wire

// [verilog/optical_measurement_sequencer.sv]
// Optical measurement sequencer with Avalon-MM register slave
//
// How it works
// R1 - Sequencer cycle is divider plus one microseconds; measurement is period cycles.
// R2 - Measurement length scales linearly with the period count.
// R3 - A run performs exactly the programmed number of measurements, or one if the count is zero.
// R4 - Pattern 0 keeps an emitter off; pattern 2 drives it every measurement.
// R5 - Patterns 3 and 4 alternate the emitters, one per measurement.
// R6 - Both patterns 2 drive both emitters in the same window.
// R7 - Emitter and integrator windows follow their own start and stop counts.
// R8 - Emitter and integrator windows are independent, so they need not overlap.
// R9 - ADC sample point moves later by the increment each measurement.
// R10 - Demodulator phases only while the sequencer runs.
// R11 - Demodulator multiplier is driven positive, zero or negative from windows.
// R12 - Software sets the signal-reference enable before using the signal path.
// R13 - High-pass cutoff is a two-bit selector with four choices.
// R14 - Emitter current starts one sequencer cycle after its start count.
// R15 - ADC base writes are ignored while the sequencer enable is set.
// R16 - ADC delay and increment carry sixteenths of a sequencer cycle.
// R17 - ADC trigger skips N iterations and fires on the next.
// R18 - Cycle counter wraps at period; run stops after the last measurement.
// R19 - Windows are active from start up to but not including stop.
`timescale 1ns/1ps
`default_nettype none

module optical_measurement_sequencer (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	// Avalon-MM slave
	input  wire logic [7:0]        i_address,
	input  wire logic              i_read,
	input  wire logic              i_write,
	input  wire logic [31:0]       i_writedata,
	input  wire logic [3:0]        i_byteenable,
	output logic      [31:0]       o_readdata,
	output logic                   o_waitrequest,
	// Analog front end controls
	output seq_pkg::afe_ctl_t      o_afe,
	output logic                   o_sigref_en,
	output logic      [1:0]        o_hpf_sel,
	output logic                   o_running
);
	import seq_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int NWIN = 5;

	logic [31:0]  reg_ctrl;
	logic [31:0]  reg_timing;
	logic [31:0]  reg_led;
	logic [31:0]  reg_itg;
	logic [31:0]  reg_sdp;
	logic [31:0]  reg_sdm1;
	logic [31:0]  reg_sdm2;
	logic [31:0]  reg_adc;
	logic [31:0]  reg_sc;
	seq_state_t   state;
	logic [15:0]  pre_cnt;
	logic [15:0]  cycle_cnt;
	logic [7:0]   meas_cnt;
	logic [7:0]   subs_cnt;
	logic [7:0]   adc_cnt;
	logic [19:0]  adc_pos;
	logic         adc_done;
	afe_ctl_t     next_afe;
	logic [15:0]  win_start [NWIN];
	logic [15:0]  win_stop  [NWIN];
	logic [NWIN-1:0] win_hit;

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	wire         cfg_en      = reg_ctrl[CTRL_EN_BIT];
	wire         cfg_demod   = reg_ctrl[CTRL_DEMOD_BIT];
	wire [2:0]   emitter_a_pattern = reg_ctrl[CTRL_PAT_A_LSB +: 3];
	wire [2:0]   emitter_b_pattern = reg_ctrl[CTRL_PAT_B_LSB +: 3];
	wire [15:0]  cfg_period  = reg_timing[TIM_PERIOD_LSB +: 16];
	wire [7:0]   cfg_div     = reg_timing[TIM_DIV_LSB +: 8];
	wire [7:0]   cfg_count   = reg_timing[TIM_COUNT_LSB +: 8];
	wire [15:0]  adc_base    = reg_adc[ADC_BASE_LSB +: 16];
	wire [7:0]   adc_inc     = reg_adc[ADC_INC_LSB +: 8];
	wire [3:0]   adc_fract   = reg_adc[ADC_FRACT_LSB +: 4];
	wire [3:0]   adc_inc_frc = reg_adc[ADC_INC_FRACT_LSB +: 4];
	wire [7:0]   demod_skip_ratio = reg_sc[SC_SKIP_LSB +: 8];

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// A request is taken at the edge where waitrequest is low
	wire         wr_go  = i_write && !o_waitrequest;
	wire         req    = i_read || i_write;
	wire [31:0]  be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
	                        {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	wire         wr_ctrl   = wr_go && (i_address == OFS_CTRL);
	wire         wr_timing = wr_go && (i_address == OFS_TIMING);
	wire         wr_led    = wr_go && (i_address == OFS_LED);
	wire         wr_itg    = wr_go && (i_address == OFS_ITG);
	wire         wr_sdp    = wr_go && (i_address == OFS_SDP);
	wire         wr_sdm1   = wr_go && (i_address == OFS_SDM1);
	wire         wr_sdm2   = wr_go && (i_address == OFS_SDM2);
	wire         wr_adc    = wr_go && (i_address == OFS_ADC);
	wire         wr_sc     = wr_go && (i_address == OFS_SC);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction : merge

	// Base sample time is frozen while enabled
	wire [31:0]  adc_lane = cfg_en ? (be_mask & 32'hFFFF_0000) : be_mask; // R15
	wire [31:0]  seq_status = {subs_cnt, meas_cnt, cycle_cnt};

	// Read data selection, unmapped reads return zero
	wire [31:0]  rd_mux =
		(i_address == OFS_CTRL)    ? reg_ctrl :
		(i_address == OFS_TIMING)  ? reg_timing :
		(i_address == OFS_LED)     ? reg_led :
		(i_address == OFS_ITG)     ? reg_itg :
		(i_address == OFS_SDP)     ? reg_sdp :
		(i_address == OFS_SDM1)    ? reg_sdm1 :
		(i_address == OFS_SDM2)    ? reg_sdm2 :
		(i_address == OFS_ADC)     ? reg_adc :
		(i_address == OFS_SC)      ? reg_sc :
		(i_address == OFS_SEQ_CNT) ? seq_status :
		(i_address == OFS_ADC_CNT) ? {24'h00_0000, adc_cnt} : RST_ZERO;

	// ----------------------------------------------------------------
	// Sequencer timebase
	// ----------------------------------------------------------------
	// One sequencer cycle is (div + 1) base steps
	wire [15:0]  step_len = 16'(({8'h00, cfg_div} + 16'h0001) * 16'(STEP_CLKS)); // R1
	wire         run      = (state == SEQ_RUN);
	wire         tick     = run && (pre_cnt == step_len - 16'h0001);
	wire         meas_end = tick && ((cycle_cnt + 16'h0001) >= cfg_period); // R18 R2
	wire         last_meas = (({1'b0, meas_cnt} + 9'h001) >= {1'b0, cfg_count});
	wire         seq_done = meas_end && last_meas; // R3

	// ----------------------------------------------------------------
	// Windows
	// ----------------------------------------------------------------
	// Emitter current lags its start by one sequencer cycle
	assign win_start[0] = 16'(reg_led[WIN_START_LSB +: 16] + 16'h0001); // R14
	assign win_stop[0]  = reg_led[WIN_STOP_LSB +: 16];
	assign win_start[1] = reg_itg[WIN_START_LSB +: 16]; // R7 R8
	assign win_stop[1]  = reg_itg[WIN_STOP_LSB +: 16];
	assign win_start[2] = reg_sdp[WIN_START_LSB +: 16];
	assign win_stop[2]  = reg_sdp[WIN_STOP_LSB +: 16];
	assign win_start[3] = reg_sdm1[WIN_START_LSB +: 16];
	assign win_stop[3]  = reg_sdm1[WIN_STOP_LSB +: 16];
	assign win_start[4] = reg_sdm2[WIN_START_LSB +: 16];
	assign win_stop[4]  = reg_sdm2[WIN_STOP_LSB +: 16];

	// One comparator per window, all on the shared counter
	for (genvar g = 0; g < NWIN; g++) begin : g_win
		window_cmp #(.W(16)) u_win (
			.i_count  (cycle_cnt),
			.i_start  (win_start[g]),
			.i_stop   (win_stop[g]),
			.o_active (win_hit[g])
		); // R19 R7
	end

	// Emitter selection by pattern and measurement parity
	wire         meas_even = ~meas_cnt[0];
	wire         emit_a_on = (emitter_a_pattern == PAT_ALWAYS) ||          // R4 R6
	                         ((emitter_a_pattern == PAT_EVEN) && meas_even) || // R5
	                         ((emitter_a_pattern == PAT_ODD) && !meas_even);
	wire         emit_b_on = (emitter_b_pattern == PAT_ALWAYS) ||          // R4 R6
	                         ((emitter_b_pattern == PAT_EVEN) && meas_even) || // R5
	                         ((emitter_b_pattern == PAT_ODD) && !meas_even);

	// ADC sample point in sixteenths of a sequencer cycle
	wire         adc_slot = (cycle_cnt == adc_pos[19:4]);
	wire         frac_ok  = ({pre_cnt, 4'h0} >= (20'(adc_pos[3:0]) * 20'(step_len))); // R16
	wire         adc_fire = run && adc_slot && frac_ok && !adc_done &&
	                        (subs_cnt == demod_skip_ratio); // R17

	// Demodulator phases only while running and enabled
	wire         dm_gate = run && cfg_demod; // R10
	wire         dm_pos  = dm_gate && win_hit[2]; // R11
	wire         dm_neg  = dm_gate && !win_hit[2] && (win_hit[3] || win_hit[4]); // R11

	assign next_afe = '{
		led_a:     run && win_hit[0] && emit_a_on,
		led_b:     run && win_hit[0] && emit_b_on,
		itg:       run && win_hit[1],
		adc_trig:  adc_fire,
		demod_pos: dm_pos,
		demod_neg: dm_neg
	};

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// One wait cycle per request, read data caught with the answer
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= RST_ZERO;
		end else begin
			o_waitrequest <= !(req && o_waitrequest);
			if (i_read && o_waitrequest) begin
				o_readdata <= rd_mux;
			end
		end
	end

	// Configuration words; a software write to control beats the end-of-run clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reg_ctrl   <= RST_ZERO;
			reg_timing <= RST_ZERO;
			reg_led    <= RST_ZERO;
			reg_itg    <= RST_ITG;
			reg_sdp    <= RST_ZERO;
			reg_sdm1   <= RST_ZERO;
			reg_sdm2   <= RST_ZERO;
			reg_adc    <= RST_ZERO;
			reg_sc     <= RST_ZERO;
		end else begin
			if (wr_ctrl) begin
				reg_ctrl <= merge(reg_ctrl, i_writedata, be_mask) & CTRL_MASK;
			end else if (seq_done) begin
				reg_ctrl[CTRL_EN_BIT] <= 1'b0; // R18
			end
			if (wr_timing) reg_timing <= merge(reg_timing, i_writedata, be_mask);
			if (wr_led)    reg_led    <= merge(reg_led, i_writedata, be_mask);
			if (wr_itg)    reg_itg    <= merge(reg_itg, i_writedata, be_mask);
			if (wr_sdp)    reg_sdp    <= merge(reg_sdp, i_writedata, be_mask);
			if (wr_sdm1)   reg_sdm1   <= merge(reg_sdm1, i_writedata, be_mask);
			if (wr_sdm2)   reg_sdm2   <= merge(reg_sdm2, i_writedata, be_mask);
			if (wr_adc)    reg_adc    <= merge(reg_adc, i_writedata, adc_lane); // R15
			if (wr_sc)     reg_sc     <= merge(reg_sc, i_writedata, be_mask) & SC_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	// Idle until enabled; stop on clear or after the last measurement
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SEQ_IDLE;
		end else begin
			case (state)
				SEQ_IDLE: if (cfg_en) state <= SEQ_RUN;
				SEQ_RUN:  if (!cfg_en || seq_done) state <= SEQ_IDLE; // R3
				default:  state <= SEQ_IDLE;
			endcase
		end
	end

	// Clock prescaler and cycle counter
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pre_cnt   <= 16'h0000;
			cycle_cnt <= 16'h0000;
		end else if (!run) begin
			pre_cnt   <= 16'h0000;
			cycle_cnt <= 16'h0000;
		end else if (tick) begin
			pre_cnt   <= 16'h0000;
			cycle_cnt <= meas_end ? 16'h0000 : cycle_cnt + 16'h0001; // R18 R1
		end else begin
			pre_cnt   <= pre_cnt + 16'h0001;
		end
	end

	// Measurement, subsampling and ADC bookkeeping
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meas_cnt <= 8'h00;
			subs_cnt <= 8'h00;
			adc_cnt  <= 8'h00;
			adc_pos  <= 20'h0_0000;
			adc_done <= 1'b0;
		end else if (!run) begin
			meas_cnt <= 8'h00;
			subs_cnt <= 8'h00;
			adc_pos  <= {adc_base, adc_fract}; // R16
			adc_done <= 1'b0;
			if (cfg_en) adc_cnt <= 8'h00;
		end else begin
			if (adc_fire) adc_cnt <= adc_cnt + 8'h01;
			if (meas_end) begin
				meas_cnt <= meas_cnt + 8'h01; // R3
				subs_cnt <= (subs_cnt == demod_skip_ratio) ? 8'h00 : subs_cnt + 8'h01; // R17
				adc_pos  <= adc_pos + 20'({adc_inc, adc_inc_frc}); // R9 R16
				adc_done <= 1'b0;
			end else if (adc_fire) begin
				adc_done <= 1'b1;
			end
		end
	end

	// Registered front-end outputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_afe       <= '0;
			o_sigref_en <= 1'b0;
			o_hpf_sel   <= 2'h0;
			o_running   <= 1'b0;
		end else begin
			o_afe       <= next_afe;
			o_sigref_en <= reg_ctrl[CTRL_SIGREF_BIT];
			o_hpf_sel   <= reg_ctrl[CTRL_HPF_LSB +: 2]; // R13
			o_running   <= run;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	bus_answer_a: assert property (req && o_waitrequest |=> !o_waitrequest)
		else $error("request not answered after one wait cycle");

	adc_base_lock_a: assert property (cfg_en && wr_adc |=> $stable(adc_base)) // R15
		else $error("base sample time changed while enabled");

	cycle_range_a: assert property (run && cfg_period != 16'h0000 |-> cycle_cnt < cfg_period) // R18
		else $error("cycle counter beyond period");

	meas_limit_a: assert property (run && cfg_count != 8'h00 |-> meas_cnt < cfg_count) // R3
		else $error("measurement count exceeded");

	led_off_a: assert property ($past(emitter_a_pattern) == PAT_OFF |-> !o_afe.led_a) // R4
		else $error("emitter A driven in off pattern");

	alternate_a: assert property ($past(emitter_a_pattern) == PAT_EVEN && // R5
	                              $past(emitter_b_pattern) == PAT_ODD |-> !(o_afe.led_a && o_afe.led_b))
		else $error("both emitters on while alternating");

	both_led_a: assert property ($past(emitter_a_pattern) == PAT_ALWAYS && // R6
	                             $past(emitter_b_pattern) == PAT_ALWAYS |-> o_afe.led_a == o_afe.led_b)
		else $error("emitters differ with both always on");

	led_delay_a: assert property (o_afe.led_a |-> $past(cycle_cnt) > $past(reg_led[WIN_START_LSB +: 16])) // R14
		else $error("emitter on before start plus one");

	demod_gate_a: assert property (!$past(run) |-> !o_afe.demod_pos && !o_afe.demod_neg) // R10
		else $error("demodulator active while idle");

	demod_excl_a: assert property (!(o_afe.demod_pos && o_afe.demod_neg)) // R11
		else $error("demodulator positive and negative together");

	adc_skip_a: assert property (o_afe.adc_trig |-> $past(subs_cnt) == $past(demod_skip_ratio)) // R17
		else $error("ADC trigger in a skipped iteration");

	adc_once_a: assert property (adc_fire |=> !adc_fire) // R9
		else $error("ADC trigger twice in a row");

	run_start_c:  cover property (!run ##1 run);
	run_done_c:   cover property (seq_done);
	adc_trig_c:   cover property (o_afe.adc_trig);
	afterglow_c:  cover property (o_afe.itg && !o_afe.led_a && $past(o_afe.led_a));

endmodule : optical_measurement_sequencer

`default_nettype wire

// [tb/afe_model.sv]
// Behavioural model of the analog front end that tallies what the sequencer drives
`timescale 1ns/1ps
`default_nettype none

module afe_model (
	// Clock and tally clear
	input  wire logic              i_clk,
	input  wire logic              i_clear,
	// Controls from the sequencer
	input  wire seq_pkg::afe_ctl_t i_afe,
	input  wire logic              i_running,
	// Tallies: index 5 emitter a, 4 emitter b, 3 integrator, 2 trigger, 1 positive, 0 negative
	output logic      [15:0]       o_hi [6],
	output logic      [15:0]       o_rise [6],
	output logic      [15:0]       o_ovl,
	output logic      [15:0]       o_idle_demod,
	output logic      [15:0]       o_both,
	output logic      [15:0]       o_run_cyc
);
	import seq_pkg::*;

	logic [5:0] bits;
	logic [5:0] last;

	// Flat view of the control struct
	assign bits = i_afe;

	// Count high cycles, rising edges and forbidden combinations
	always_ff @(posedge i_clk) begin
		last <= i_clear ? 6'h00 : bits;
		for (int k = 0; k < 6; k++) begin
			o_hi[k]   <= i_clear ? 16'h0000 : o_hi[k] + 16'(bits[k]);
			o_rise[k] <= i_clear ? 16'h0000 : o_rise[k] + 16'(bits[k] & ~last[k]);
		end
		o_ovl        <= i_clear ? 16'h0000 : o_ovl + 16'((bits[5] | bits[4]) & bits[3]);
		o_idle_demod <= i_clear ? 16'h0000 : o_idle_demod + 16'((bits[1] | bits[0]) & ~i_running);
		o_both       <= i_clear ? 16'h0000 : o_both + 16'(bits[5] & bits[4]);
		o_run_cyc    <= i_clear ? 16'h0000 : o_run_cyc + 16'(i_running);
	end

endmodule : afe_model

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the optical measurement sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
	import seq_pkg::*;

	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  i_address = 8'h00;
	logic        i_read = 1'b0;
	logic        i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0000_0000;
	logic [3:0]  i_byteenable = 4'hF;
	logic [31:0] o_readdata;
	logic        o_waitrequest;
	afe_ctl_t    o_afe;
	logic        o_sigref_en;
	logic [1:0]  o_hpf_sel;
	logic        o_running;
	logic        clear = 1'b1;
	logic [15:0] hi [6];
	logic [15:0] rise [6];
	logic [15:0] ovl, idle_demod, both, run_cyc;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [31:0] q;
	logic [15:0] trig_at = 16'h0000;
	logic [3:0]  pa [5] = '{4'h2, 4'h0, 4'h3, 4'h2, 4'h1};
	logic [3:0]  pb [5] = '{4'h0, 4'h2, 4'h4, 4'h2, 4'h5};
	logic [15:0] ea [5] = '{16'h0004, 16'h0000, 16'h0002, 16'h0004, 16'h0000};
	logic [15:0] eb [5] = '{16'h0000, 16'h0004, 16'h0002, 16'h0004, 16'h0000};

	optical_measurement_sequencer u_optical_measurement_sequencer (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_afe(o_afe),
		.o_sigref_en(o_sigref_en), .o_hpf_sel(o_hpf_sel), .o_running(o_running));

	afe_model u_afe_model (.i_clk(i_clk), .i_clear(clear), .i_afe(o_afe), .i_running(o_running), .o_hi(hi),
		.o_rise(rise), .o_ovl(ovl), .o_idle_demod(idle_demod), .o_both(both), .o_run_cyc(run_cyc));

	// Clock and hang guard
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			error_cnt++;
			stop_test();
		end
	end

	// Run time, in clocks, of the latest ADC trigger seen by the front end
	always @(posedge i_clk) begin
		if (o_afe.adc_trig) trig_at <= run_cyc;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One Avalon access held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge i_clk);
		i_address   <= a;
		i_writedata <= d;
		i_write     <= wr;
		i_read      <= ~wr;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		r = o_readdata;
		i_write <= 1'b0;
		i_read  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask : rdc

	// Clear tallies and start a run
	task automatic start(input logic [31:0] ctrl);
		@(posedge i_clk);
		clear <= 1'b1;
		@(posedge i_clk);
		clear <= 1'b0;
		wr(OFS_CTRL, ctrl);
	endtask : start

	// Wait for the run to begin and end
	task automatic finish_run();
		for (int n = 0; n < 200 && o_running !== 1'b1; n++) @(posedge i_clk);
		for (int n = 0; n < 50000 && o_running !== 1'b0; n++) @(posedge i_clk);
		// A run that never ends is a mismatch
		if (o_running !== 1'b0) begin
			error_cnt++;
			stop_test();
		end else begin
			repeat (3) @(posedge i_clk);
		end
	endtask : finish_run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rdc(OFS_CTRL, RST_ZERO);
		rdc(OFS_ITG, RST_ITG);
		rdc(8'h10, 32'h0000_0000);
		wr(OFS_CTRL, 32'hFFFF_FFFE);
		rdc(OFS_CTRL, 32'h0000_7736);
		chk(o_sigref_en, 1'b1);
		chk(o_hpf_sel, 2'h3);
		wr(OFS_CTRL, 32'h0000_0014);
		// Selector is a registered copy, one clock behind the control word
		repeat (2) @(posedge i_clk);
		chk(o_hpf_sel, 2'h1);
		// Emitter window ends exactly where integration starts
		wr(OFS_TIMING, 32'h0400_000A);
		wr(OFS_LED, 32'h0002_0005);
		wr(OFS_ITG, 32'h0005_0009);
		wr(OFS_ADC, 32'h0001_0002);
		for (int i = 0; i < 5; i++) begin
			start({16'h0000, pb[i], pa[i], 8'h01});
			finish_run();
			chk(rise[5], ea[i]);
			chk(rise[4], eb[i]);
			chk(hi[5], ea[i] * 16'd200);
			chk(both, (i == 3) ? 16'd800 : 16'd0);
			chk(hi[3], 16'd1600);
			chk(ovl, 16'h0000);
			chk(run_cyc, 16'd4000);
			chk(rise[2], 16'h0004);
			chk(trig_at, 16'd3500);
		end
		rdc(OFS_CTRL, 32'h0000_5100);
		rdc(OFS_ADC_CNT, 32'h0000_0004);
		// Longer sequencer cycle, then a shorter period
		wr(OFS_TIMING, 32'h0201_000A);
		start(32'h0000_0201);
		finish_run();
		chk(run_cyc, 16'd4000);
		chk(hi[5], 16'd800);
		wr(OFS_TIMING, 32'h0201_0005);
		start(32'h0000_0201);
		finish_run();
		chk(run_cyc, 16'd2000);
		// Trigger skipping and base write while running
		wr(OFS_TIMING, 32'h0400_000A);
		wr(OFS_SC, 32'h0000_2000);
		start(32'h0000_0201);
		wr(OFS_ADC, 32'h0001_0007);
		rdc(OFS_ADC, 32'h0001_0002);
		finish_run();
		chk(rise[2], 16'h0002);
		chk(hi[2], 16'h0002);
		chk(trig_at, 16'd3500);
		wr(OFS_SC, 32'h0000_0000);
		// Demodulator phases during a run only
		wr(OFS_SDP, 32'h0002_0004);
		wr(OFS_SDM1, 32'h0004_0006);
		start(32'h0000_0207);
		finish_run();
		chk(hi[1], 16'd800);
		chk(hi[0], 16'd800);
		chk(idle_demod, 16'h0000);
		stop_test();
	end

endmodule : tb

`default_nettype wire
